/* hw/rcb_pkg.sv */
`default_nettype none
package rcb_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int IDX_W = 7;

    // ----------------------------------------
    // configuration indexes
    // ----------------------------------------
    localparam logic [7:0] CFG_ACTIVATE = 8'h30;
    localparam logic [7:0] CFG_B0_HIGH = 8'h60;
    localparam logic [7:0] CFG_B0_LOW = 8'h61;
    localparam logic [7:0] CFG_B1_HIGH = 8'h62;
    localparam logic [7:0] CFG_B1_LOW = 8'h63;
    localparam logic [7:0] CFG_SHADOW = 8'hF1;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_B0_HIGH = 8'h00;
    localparam logic [7:0] RST_B0_LOW = 8'h70;
    localparam logic [7:0] RST_B1_HIGH = 8'h00;
    localparam logic [7:0] RST_B1_LOW = 8'h74;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int ACT_BANK0_BIT = 0;
    localparam int ACT_BANK1_BIT = 1;
    localparam logic [7:0] ACT_MASK = 8'h03;
    localparam logic [7:0] HIGH_MASK = 8'h0F;
    localparam logic [7:0] LOW_MASK = 8'hFE;
    localparam logic [15:0] B0_DATA_OFS = 16'h0001;
    localparam logic [15:0] B1_DATA_OFS = 16'h0002;

    // ----------------------------------------
    // bank index map
    // ----------------------------------------
    localparam logic [6:0] IDX_CTRL_A = 7'h0A;
    localparam logic [6:0] IDX_CTRL_B = 7'h0B;
    localparam logic [6:0] IDX_CTRL_C = 7'h0C;
    localparam logic [6:0] IDX_CTRL_D = 7'h0D;
    localparam logic [6:0] IDX_CENTURY = 7'h32;
    localparam logic [6:0] IDX_SHARED = 7'h7F;
    localparam logic [7:0] CTRL_A_WMASK = 8'h7F;
    localparam logic [7:0] CTRL_B_WMASK = 8'hFE;
    localparam logic [7:0] CTRL_D_WMASK = 8'h3F;
    localparam logic [7:0] CTRL_D_VALID = 8'h80;

    // ----------------------------------------
    // run-time port select
    // ----------------------------------------
    typedef enum logic [1:0] {
        RCB_B0_INDEX,
        RCB_B0_DATA,
        RCB_B1_INDEX,
        RCB_B1_DATA
    } rcb_port_t;
endpackage
`default_nettype wire

/* hw/rcb_port_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module rcb_port_decode #(
    parameter logic [15:0] DATA_OFS = 16'h0001
) (
    // bank enable and base
    input wire logic enable,
    input wire logic [7:0] baseHigh,
    input wire logic [7:0] baseLow,
    // host address
    input wire logic [rcb_pkg::ADDR_W-1:0] ioAddr,
    // hits
    output logic indexHit,
    output logic dataHit
);
    import rcb_pkg::*;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    if (DATA_OFS == 16'h0000 || ADDR_W != 16) begin : g_bad
        $error("rcb_port_decode: data offset or address width unsupported");
    end

    // base from A11..A1, upper address bits zero
    function automatic logic [15:0] portBase(input logic [7:0] hi, input logic [7:0] lo);
        portBase = {4'h0, hi[3:0], lo[7:1], 1'b0};
    endfunction

    logic [15:0] base;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // index at base, data at base plus offset
    assign base = portBase(baseHigh, baseLow);
    assign indexHit = enable && (ioAddr == base);
    assign dataHit = enable && (ioAddr == base + DATA_OFS);
endmodule
`default_nettype wire

/* hw/rcb_bank_access.sv */
// Summary of operation
// - Bank-0 clock and memory ports decode only while activate bit 0 set.
// - Bank-1 memory ports decode only while activate bit 1 set.
// - Each bank base is A11..A1 from a high/low byte pair; masked bits zero.
// - Index port at base; bank-0 data at base+1, bank-1 data at base+2.
// - Index bit 7 is ignored; seven bits select the location.
// - All four index and data ports read and write; index reads back.
// - Index 0x7F of either bank is the single shared clock-control byte.
// - Bank-0 indexes 0 to 9 are the read/write time and alarm bytes.
// - Bank-0 0xA-0xD are control bytes; B bit 0 and C are read-only.
// - Bank 0 holds century at 0x32; day alarm shares control byte D.
// - Remaining bank-0 and bank-1 indexes below 0x7F are plain storage.
// - Last value written to bank-0 index reads back at config 0xF1.
// - Host and microcontroller both reach the index and data ports.
// - Clock interrupt drives a dedicated parallel interrupt-8 pin.
// - Control byte C ignores all writes.
// - Control byte D bit 7 is read-only, set only by reading D.
// - Shared control bits 7 to 1 are read-only.
`timescale 1ns/1ps
`default_nettype none
module rcb_bank_access (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // host i/o cycles
    input wire logic [rcb_pkg::ADDR_W-1:0] ioAddr,
    input wire logic ioRd,
    input wire logic ioWr,
    input wire logic [rcb_pkg::DATA_W-1:0] ioWdata,
    output logic ioClaim,
    output logic [rcb_pkg::DATA_W-1:0] ioRdata,
    output logic ioRdValid,
    // configuration registers
    input wire logic [7:0] cfgIndex,
    input wire logic cfgRd,
    input wire logic cfgWr,
    input wire logic [7:0] cfgWdata,
    output logic [7:0] cfgRdata,
    output logic cfgRdValid,
    // microcontroller access
    input wire rcb_pkg::rcb_port_t mcPort,
    input wire logic mcRd,
    input wire logic mcWr,
    input wire logic [rcb_pkg::DATA_W-1:0] mcWdata,
    output logic mcReady,
    output logic [rcb_pkg::DATA_W-1:0] mcRdata,
    output logic mcRdValid,
    // timekeeping core
    input wire logic [rcb_pkg::IDX_W-1:0] coreIdx,
    input wire logic coreWr,
    input wire logic [rcb_pkg::DATA_W-1:0] coreWdata,
    output logic coreAck,
    output logic [rcb_pkg::DATA_W-1:0] coreRdata,
    input wire logic coreUip,
    input wire logic coreRegB0,
    input wire logic [7:0] coreRegC,
    input wire logic [6:0] coreSharedRo,
    input wire logic coreIrq,
    output logic [7:0] ctrlA,
    output logic [7:0] ctrlB,
    output logic [7:0] ctrlD,
    output logic sharedCtrl0,
    // interrupt pin
    output logic clockInterruptPin_n
);
    import rcb_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] mem [0:255];
    logic [7:0] activate;
    logic [7:0] b0High;
    logic [7:0] b0Low;
    logic [7:0] b1High;
    logic [7:0] b1Low;
    logic [7:0] b0Index;
    logic [7:0] b1Index;

    // ----------------------------------------
    // access path signals
    // ----------------------------------------
    logic b0IdxHit;
    logic b0DataHit;
    logic b1IdxHit;
    logic b1DataHit;
    logic hostAcc;
    logic mcAcc;
    rcb_port_t accPort;
    logic accRd;
    logic accWr;
    logic [7:0] accWdata;
    logic accBank;
    logic accData;
    logic [6:0] accIdx;
    logic [7:0] rdByte;
    logic memWrite;

    // control bytes and shared byte are not plain memory
    function automatic logic isCtrl(input logic bank, input logic [6:0] idx);
        isCtrl = (idx == IDX_SHARED) ||
            (!bank && idx >= IDX_CTRL_A && idx <= IDX_CTRL_D);
    endfunction

    // byte seen at a location, read-only parts from the core
    function automatic logic [7:0] readLoc(input logic bank, input logic [6:0] idx);
        if (idx == IDX_SHARED) begin
            readLoc = {coreSharedRo, sharedCtrl0};
        end else if (!bank && idx == IDX_CTRL_A) begin
            readLoc = {coreUip, ctrlA[6:0]};
        end else if (!bank && idx == IDX_CTRL_B) begin
            readLoc = {ctrlB[7:1], coreRegB0};
        end else if (!bank && idx == IDX_CTRL_C) begin
            readLoc = coreRegC;
        end else if (!bank && idx == IDX_CTRL_D) begin
            readLoc = ctrlD;
        end else begin
            readLoc = mem[{bank, idx}];
        end
    endfunction

    // ----------------------------------------
    // port decode
    // ----------------------------------------
    // bank-0 decoder, enabled by activate bit 0
    rcb_port_decode #(
        .DATA_OFS(B0_DATA_OFS)
    ) u_dec0 (
        .enable(activate[ACT_BANK0_BIT]),
        .baseHigh(b0High),
        .baseLow(b0Low),
        .ioAddr(ioAddr),
        .indexHit(b0IdxHit),
        .dataHit(b0DataHit)
    );

    // bank-1 decoder, enabled by activate bit 1
    rcb_port_decode #(
        .DATA_OFS(B1_DATA_OFS)
    ) u_dec1 (
        .enable(activate[ACT_BANK1_BIT]),
        .baseHigh(b1High),
        .baseLow(b1Low),
        .ioAddr(ioAddr),
        .indexHit(b1IdxHit),
        .dataHit(b1DataHit)
    );

    // claim only decoded, active ports; host beats microcontroller
    assign hostAcc = (ioRd || ioWr) && (b0IdxHit || b0DataHit || b1IdxHit || b1DataHit);
    assign ioClaim = hostAcc;
    assign mcReady = !hostAcc;
    assign mcAcc = (mcRd || mcWr) && !hostAcc;

    // ----------------------------------------
    // access select
    // ----------------------------------------
    // one access per cycle from host or microcontroller
    always_comb begin
        accPort = mcPort;
        accRd = mcAcc && mcRd;
        accWr = mcAcc && mcWr;
        accWdata = mcWdata;
        if (hostAcc) begin
            accRd = ioRd;
            accWr = ioWr;
            accWdata = ioWdata;
            if (b0IdxHit) begin
                accPort = RCB_B0_INDEX;
            end else if (b0DataHit) begin
                accPort = RCB_B0_DATA;
            end else if (b1IdxHit) begin
                accPort = RCB_B1_INDEX;
            end else begin
                accPort = RCB_B1_DATA;
            end
        end
    end

    // bank, kind and seven-bit location of the access
    assign accBank = (accPort == RCB_B1_INDEX) || (accPort == RCB_B1_DATA);
    assign accData = (accPort == RCB_B0_DATA) || (accPort == RCB_B1_DATA);
    assign accIdx = accBank ? b1Index[6:0] : b0Index[6:0];
    assign memWrite = accWr && accData && !isCtrl(accBank, accIdx);

    // index ports read back whole; data ports read the location
    always_comb begin
        if (accData) begin
            rdByte = readLoc(accBank, accIdx);
        end else begin
            rdByte = accBank ? b1Index : b0Index;
        end
    end

    // ----------------------------------------
    // index registers
    // ----------------------------------------
    // bank-0 index, also the shadow copy
    always_ff @(posedge clock) begin
        if (rst) begin
            b0Index <= RST_INDEX;
        end else if (ce && accWr && accPort == RCB_B0_INDEX) begin
            b0Index <= accWdata;
        end
    end

    // bank-1 index
    always_ff @(posedge clock) begin
        if (rst) begin
            b1Index <= RST_INDEX;
        end else if (ce && accWr && accPort == RCB_B1_INDEX) begin
            b1Index <= accWdata;
        end
    end

    // ----------------------------------------
    // memory array
    // ----------------------------------------
    // shared byte lives outside the array, so both banks see one copy
    always_ff @(posedge clock) begin
        if (ce) begin
            if (memWrite) begin
                mem[{accBank, accIdx}] <= accWdata;
            end else if (coreWr && !isCtrl(1'b0, coreIdx)) begin
                mem[{1'b0, coreIdx}] <= coreWdata;
            end
        end
    end

    // core sees its write taken when no port write collides
    assign coreAck = ce && coreWr && !memWrite;

    // core read of bank-0 time bytes
    always_ff @(posedge clock) begin
        if (rst) begin
            coreRdata <= RST_CTRL;
        end else if (ce) begin
            coreRdata <= mem[{1'b0, coreIdx}];
        end
    end

    // ----------------------------------------
    // control bytes
    // ----------------------------------------
    // control A, update flag bit comes from the core
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrlA <= RST_CTRL;
        end else if (ce && accWr && accData && !accBank && accIdx == IDX_CTRL_A) begin
            ctrlA <= accWdata & CTRL_A_WMASK;
        end
    end

    // control B, bit 0 held read-only
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrlB <= RST_CTRL;
        end else if (ce && accWr && accData && !accBank && accIdx == IDX_CTRL_B) begin
            ctrlB <= accWdata & CTRL_B_WMASK;
        end
    end

    // control C takes no write at all; its value is the core's

    // control D: valid flag set by a read, day alarm in low bits
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrlD <= RST_CTRL;
        end else if (ce && accData && !accBank && accIdx == IDX_CTRL_D) begin
            if (accWr) begin
                ctrlD <= (ctrlD & ~CTRL_D_WMASK) | (accWdata & CTRL_D_WMASK);
            end
            if (accRd) begin
                ctrlD <= ctrlD | CTRL_D_VALID;
            end
        end
    end

    // shared control, only bit 0 writable
    always_ff @(posedge clock) begin
        if (rst) begin
            sharedCtrl0 <= 1'b0;
        end else if (ce && accWr && accData && accIdx == IDX_SHARED) begin
            sharedCtrl0 <= accWdata[0];
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // activate and base pairs with fixed-zero bits masked
    always_ff @(posedge clock) begin
        if (rst) begin
            activate <= RST_ACTIVATE;
            b0High <= RST_B0_HIGH;
            b0Low <= RST_B0_LOW;
            b1High <= RST_B1_HIGH;
            b1Low <= RST_B1_LOW;
        end else if (ce && cfgWr) begin
            case (cfgIndex)
                CFG_ACTIVATE: activate <= cfgWdata & ACT_MASK;
                CFG_B0_HIGH: b0High <= cfgWdata & HIGH_MASK;
                CFG_B0_LOW: b0Low <= cfgWdata & LOW_MASK;
                CFG_B1_HIGH: b1High <= cfgWdata & HIGH_MASK;
                CFG_B1_LOW: b1Low <= cfgWdata & LOW_MASK;
                default: ;
            endcase
        end
    end

    // configuration read-back, unknown indexes read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            cfgRdata <= RST_CTRL;
            cfgRdValid <= 1'b0;
        end else if (ce) begin
            cfgRdValid <= cfgRd;
            case (cfgIndex)
                CFG_ACTIVATE: cfgRdata <= activate;
                CFG_B0_HIGH: cfgRdata <= b0High;
                CFG_B0_LOW: cfgRdata <= b0Low;
                CFG_B1_HIGH: cfgRdata <= b1High;
                CFG_B1_LOW: cfgRdata <= b1Low;
                CFG_SHADOW: cfgRdata <= b0Index;
                default: cfgRdata <= RST_CTRL;
            endcase
        end
    end

    // ----------------------------------------
    // read answers
    // ----------------------------------------
    // host answer one cycle after the claimed read
    always_ff @(posedge clock) begin
        if (rst) begin
            ioRdata <= RST_CTRL;
            ioRdValid <= 1'b0;
        end else if (ce) begin
            ioRdValid <= hostAcc && ioRd;
            if (hostAcc && ioRd) begin
                ioRdata <= rdByte;
            end
        end
    end

    // microcontroller answer one cycle after its read is taken
    always_ff @(posedge clock) begin
        if (rst) begin
            mcRdata <= RST_CTRL;
            mcRdValid <= 1'b0;
        end else if (ce) begin
            mcRdValid <= mcAcc && mcRd;
            if (mcAcc && mcRd) begin
                mcRdata <= rdByte;
            end
        end
    end

    // ----------------------------------------
    // interrupt pin
    // ----------------------------------------
    // dedicated active-low parallel pin, released in reset
    always_ff @(posedge clock) begin
        if (rst) begin
            clockInterruptPin_n <= 1'b1;
        end else if (ce) begin
            clockInterruptPin_n <= !coreIrq;
        end
    end
endmodule
`default_nettype wire

/* tb/rcb_bank_access_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rcb_bank_access_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // host side
    input wire logic [rcb_pkg::ADDR_W-1:0] ioAddr,
    input wire logic ioRd,
    input wire logic ioWr,
    input wire logic ioClaim,
    input wire logic ioRdValid,
    // config and microcontroller side
    input wire logic cfgRd,
    input wire logic cfgRdValid,
    input wire logic mcRd,
    input wire logic mcReady,
    input wire logic mcRdValid,
    // core side
    input wire logic coreIrq,
    input wire logic [7:0] ctrlB,
    input wire logic [7:0] ctrlD,
    input wire logic clockInterruptPin_n
);
    import rcb_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_claim_needs_strobe: assert property (ioClaim |-> (ioRd || ioWr))
        else $error("claim without strobe");
    a_claim_high_zero: assert property (ioClaim |-> ioAddr[15:12] == 4'h0)
        else $error("claim above 12-bit range");
    a_read_gives_valid: assert property (ce && ioClaim && ioRd |=> ioRdValid)
        else $error("claimed read without valid");
    a_valid_has_cause: assert property (ioRdValid |-> $past(ce && ioClaim && ioRd))
        else $error("read valid without claimed read");
    a_mc_yields_host: assert property (ioClaim |-> !mcReady)
        else $error("mc ready during host access");
    a_mc_read_valid: assert property (ce && mcRd && mcReady |=> mcRdValid)
        else $error("mc read without valid");
    a_cfg_read_valid: assert property (ce |=> cfgRdValid == $past(cfgRd))
        else $error("config read valid wrong");
    a_ctrlb_bit_zero: assert property (!ctrlB[0])
        else $error("control B bit 0 stored");
    a_ctrld_bit_six: assert property (!ctrlD[6])
        else $error("control D bit 6 stored");
    a_pin_follows_irq: assert property (ce && !rst |=> clockInterruptPin_n == !$past(coreIrq))
        else $error("interrupt pin wrong");
    // main scenarios
    c_host_read: cover property (ioRdValid);
    c_mc_read: cover property (mcRdValid);
    c_mc_waits: cover property (mcRd && !mcReady);
    c_pin_low: cover property (!clockInterruptPin_n);
endmodule
bind rcb_bank_access rcb_bank_access_asserts u_chk (.clock, .rst, .ce, .ioAddr, .ioRd,
    .ioWr, .ioClaim, .ioRdValid, .cfgRd, .cfgRdValid, .mcRd, .mcReady, .mcRdValid,
    .coreIrq, .ctrlB, .ctrlD, .clockInterruptPin_n);
`default_nettype wire

/* tb/rcb_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcb_core_model #(
    parameter logic [7:0] REG_C = 8'hC3,
    parameter logic [6:0] SHARED_RO = 7'h55
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bench control and handshake
    input wire logic irqReq,
    input wire logic coreAck,
    // core side of the bank
    output logic [6:0] coreIdx,
    output logic coreWr,
    output logic [7:0] coreWdata,
    output logic coreUip,
    output logic coreRegB0,
    output logic [7:0] coreRegC,
    output logic [6:0] coreSharedRo,
    output logic coreIrq
);
    logic wrDone;
    // one core write per reset, held until acked
    always_ff @(posedge clock) begin
        if (rst) begin
            wrDone <= 1'b0;
        end else if (coreAck) begin
            wrDone <= 1'b1;
        end
    end
    assign coreWr = (wrDone === 1'b0);
    assign coreIdx = 7'h20;
    assign coreWdata = 8'h5A;
    // fixed status bits seen through the ports; interrupt follows irqReq
    assign coreUip = 1'b1;
    assign coreRegB0 = 1'b1;
    assign coreRegC = REG_C;
    assign coreSharedRo = SHARED_RO;
    assign coreIrq = irqReq;
endmodule
`default_nettype wire

/* tb/tb_rtc_cmos_bank_access.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_rtc_cmos_bank_access;
    import rcb_pkg::*;
    typedef struct packed {
        logic wb;
        logic rb;
        logic [7:0] wi;
        logic [7:0] ri;
        logic [7:0] wd;
        logic [7:0] ex;
    } rcb_row_t;
    localparam rcb_row_t ROWS [11] = '{
        '{0, 0, 8'h00, 8'h00, 8'h12, 8'h12}, '{0, 0, 8'h09, 8'h09, 8'h99, 8'h99},
        '{0, 0, 8'h85, 8'h05, 8'h3C, 8'h3C}, '{0, 0, 8'h0E, 8'h0E, 8'hA5, 8'hA5},
        '{0, 0, 8'h32, 8'h32, 8'h20, 8'h20}, '{1, 1, 8'h00, 8'h00, 8'h77, 8'h77},
        '{0, 0, 8'h0C, 8'h0C, 8'hFF, 8'hC3}, '{0, 0, 8'h0B, 8'h0B, 8'h00, 8'h01},
        '{0, 0, 8'h0A, 8'h0A, 8'h00, 8'h80}, '{1, 0, 8'h7F, 8'h7F, 8'hFF, 8'hAB},
        '{0, 1, 8'h7F, 8'h7F, 8'h00, 8'hAA}};
    localparam logic [7:0] CI [5] = '{CFG_ACTIVATE, CFG_B0_HIGH, CFG_B0_LOW, CFG_B1_HIGH,
        CFG_B1_LOW};
    localparam logic [7:0] CR [5] = '{RST_ACTIVATE, RST_B0_HIGH, RST_B0_LOW, RST_B1_HIGH,
        RST_B1_LOW};
    logic clock, rst, ioRd, ioWr, ioClaim, ioRdValid, cfgRd, cfgWr, cfgRdValid;
    logic mcRd, mcWr, mcReady, mcRdValid, coreWr, coreAck, coreUip, coreRegB0;
    logic coreIrq, irqReq, sharedCtrl0, pinN, cl, ce;
    logic [15:0] ioAddr;
    logic [7:0] ioWdata, ioRdata, cfgIndex, cfgWdata, cfgRdata, mcWdata, mcRdata;
    logic [7:0] coreWdata, coreRegC, ctrlA, ctrlB, ctrlD, q, mq, coreRdata;
    logic [6:0] coreIdx, coreSharedRo;
    rcb_port_t mcPort;
    int fail_count, tests_run;
    // ----------------------------------------
    // design and far-side model
    // ----------------------------------------
    rcb_bank_access u_dut (.clock(clock), .rst(rst), .ce(ce), .ioAddr(ioAddr), .ioRd(ioRd),
        .ioWr(ioWr), .ioWdata(ioWdata), .ioClaim(ioClaim), .ioRdata(ioRdata),
        .ioRdValid(ioRdValid), .cfgIndex(cfgIndex), .cfgRd(cfgRd), .cfgWr(cfgWr),
        .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid), .mcPort(mcPort),
        .mcRd(mcRd), .mcWr(mcWr), .mcWdata(mcWdata), .mcReady(mcReady), .mcRdata(mcRdata),
        .mcRdValid(mcRdValid), .coreIdx(coreIdx), .coreWr(coreWr), .coreWdata(coreWdata),
        .coreAck(coreAck), .coreRdata(coreRdata), .coreUip(coreUip), .coreRegB0(coreRegB0),
        .coreRegC(coreRegC), .coreSharedRo(coreSharedRo), .coreIrq(coreIrq), .ctrlA(ctrlA),
        .ctrlB(ctrlB), .ctrlD(ctrlD), .sharedCtrl0(sharedCtrl0), .clockInterruptPin_n(pinN));
    rcb_core_model u_core (.clock(clock), .rst(rst), .irqReq(irqReq), .coreAck(coreAck),
        .coreIdx(coreIdx), .coreWr(coreWr), .coreWdata(coreWdata), .coreUip(coreUip),
        .coreRegB0(coreRegB0), .coreRegC(coreRegC), .coreSharedRo(coreSharedRo),
        .coreIrq(coreIrq));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    function automatic logic [15:0] pa(input logic b, input logic d);
        return b ? (16'h0074 + (d ? 16'h0002 : 16'h0000)) : (16'h0070 + 16'(d));
    endfunction
    task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge clock);
        ioAddr <= a;
        ioRd <= !w;
        ioWr <= w;
        ioWdata <= d;
        @(negedge clock) cl = ioClaim;
        @(posedge clock);
        ioRd <= 1'b0;
        ioWr <= 1'b0;
        @(negedge clock) q = ioRdata;
    endtask
    task automatic cfg(input logic [7:0] i, input logic w, input logic [7:0] d);
        @(posedge clock);
        cfgIndex <= i;
        cfgRd <= !w;
        cfgWr <= w;
        cfgWdata <= d;
        @(posedge clock);
        cfgRd <= 1'b0;
        cfgWr <= 1'b0;
        @(negedge clock) q = cfgRdata;
    endtask
    task automatic mc(input rcb_port_t p, input logic w, input logic [7:0] d);
        logic r;
        r = 1'b0;
        @(posedge clock);
        mcPort <= p;
        mcRd <= !w;
        mcWr <= w;
        mcWdata <= d;
        for (int i = 0; i < 8 && !r; i++) begin
            @(negedge clock) r = mcReady;
            @(posedge clock);
        end
        mcRd <= 1'b0;
        mcWr <= 1'b0;
        @(negedge clock) mq = mcRdata;
        if (!r) begin
            fail_count++;
            $display("[ERR] %0t mc port never ready", $time);
            report_and_stop();
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock and main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = !clock;
    end
    initial begin
        {ioRd, ioWr, cfgRd, cfgWr, mcRd, mcWr, irqReq} = '0;
        {ioAddr, ioWdata, cfgIndex, cfgWdata, mcWdata} = '0;
        mcPort = RCB_B0_INDEX;
        ce = 1'b1;
        fail_count = 0;
        tests_run = 0;
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        cfg(CFG_ACTIVATE, 1, 8'h03);
        // table of index and data accesses
        foreach (ROWS[n]) begin
            io(pa(ROWS[n].wb, 0), 1, ROWS[n].wi);
            io(pa(ROWS[n].wb, 1), 1, ROWS[n].wd);
            io(pa(ROWS[n].rb, 0), 1, ROWS[n].ri);
            io(pa(ROWS[n].rb, 0), 0, 8'h00);
            `CHK(q, ROWS[n].ri)
            io(pa(ROWS[n].rb, 1), 0, 8'h00);
            `CHK(q, ROWS[n].ex)
        end
        `CHK(sharedCtrl0, 1'b0)
        `CHK(ctrlA, 8'h00)
        $display("table done");
        // control D: write, then read twice
        io(16'h0070, 1, 8'h0D);
        io(16'h0071, 1, 8'hFF);
        io(16'h0071, 0, 8'h00);
        io(16'h0071, 0, 8'h00);
        `CHK(q, 8'hBF)
        `CHK(ctrlD, 8'hBF)
        $display("control D done");
        // masked base bits and relocation
        cfg(CFG_B0_HIGH, 1, 8'hFF);
        cfg(CFG_B0_HIGH, 0, 8'h00);
        `CHK(q, 8'h0F)
        cfg(CFG_B0_LOW, 1, 8'hFF);
        cfg(CFG_B0_LOW, 0, 8'h00);
        `CHK(q, 8'hFE)
        cfg(CFG_B0_HIGH, 1, 8'h01);
        cfg(CFG_B0_LOW, 1, 8'h72);
        io(16'h0070, 0, 8'h00);
        `CHK(cl, 1'b0)
        io(16'h1172, 0, 8'h00);
        `CHK(cl, 1'b0)
        io(16'h0172, 1, 8'h11);
        io(16'h0172, 0, 8'h00);
        `CHK(q, 8'h11)
        cfg(CFG_SHADOW, 0, 8'h00);
        `CHK(q, 8'h11)
        $display("relocation done");
        // activation bits gate each bank
        cfg(CFG_ACTIVATE, 1, 8'h01);
        io(16'h0074, 0, 8'h00);
        `CHK(cl, 1'b0)
        cfg(CFG_ACTIVATE, 1, 8'h02);
        io(16'h0172, 0, 8'h00);
        `CHK(cl, 1'b0)
        $display("activation done");
        // microcontroller path, colliding with a host read
        cfg(CFG_ACTIVATE, 1, 8'h01);
        mc(RCB_B0_INDEX, 1, 8'h20);
        fork
            io(16'h0172, 0, 8'h00);
            mc(RCB_B0_DATA, 0, 8'h00);
        join
        `CHK(q, 8'h20)
        `CHK(mq, 8'h5A)
        `CHK(coreRdata, 8'h5A)
        $display("microcontroller done");
        // clock enable low freezes the index register
        @(posedge clock) ce <= 1'b0;
        io(16'h0172, 1, 8'h44);
        @(posedge clock) ce <= 1'b1;
        io(16'h0172, 0, 8'h00);
        `CHK(q, 8'h20)
        $display("enable done");
        // interrupt pin
        @(posedge clock) irqReq <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock) `CHK(pinN, 1'b0)
        @(posedge clock) irqReq <= 1'b0;
        $display("interrupt done");
        // second reset restores config values and closes the ports
        @(posedge clock) rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (CI[n]) begin
            cfg(CI[n], 0, 8'h00);
            `CHK(q, CR[n])
        end
        io(16'h0070, 0, 8'h00);
        `CHK(cl, 1'b0)
        $display("reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
